// ### core/thermal_params.svh
// Constants for the thermal monitor and analog mux controller
`ifndef THERMAL_PARAMS_SVH
`define THERMAL_PARAMS_SVH

// Clock rates and the derived low-frequency tick divider
`define MCLK_KHZ            40000
`define LFCLK_KHZ           100
`define LF_DIV              (`MCLK_KHZ / `LFCLK_KHZ)

// Debounce time (least time, rounded up to whole ticks)
`define DEBOUNCE_US         10
`define DEBOUNCE_TICKS      ((`DEBOUNCE_US * `LFCLK_KHZ + 999) / 1000)

// Sampling window 450 us and interval 3.0 ms (longest times, rounded down)
`define SAMPLE_WINDOW_US    450
`define SAMPLE_INTERVAL_US  3000
`define SAMPLE_WINDOW_TICKS ((`SAMPLE_WINDOW_US * `LFCLK_KHZ) / 1000)
`define SAMPLE_PERIOD_TICKS ((`SAMPLE_INTERVAL_US * `LFCLK_KHZ) / 1000)

// Register byte offsets
`define REG_CTRL            12'h000
`define REG_STATUS          12'h004
`define REG_MASK            12'h008
`define REG_SENSE           12'h00C

// Control register fields
`define CTRL_MON_EN         0
`define CTRL_MON_AON        1
`define CTRL_MUX_EN         2
`define CTRL_SEL_LSB        4
`define CTRL_SEL_MSB        8

// Sense register extra fields
`define SENSE_SHUTDOWN      6
`define SENSE_POWERED       7

// Event bit of the shutdown comparator in status and mask
`define EVT_SHUTDOWN        6

// Reset values
`define CTRL_MON_EN_RST     1'b1
`define CTRL_MON_AON_RST    1'b0
`define CTRL_MUX_EN_RST     1'b0
`define CTRL_SEL_RST        5'h00
`define MASK_RST            7'h7F

// Channel select codes
`define MUX_SEL_HIZ         5'h00
`define MUX_SEL_DIE_TEMP    5'h07

`endif

// ### core/thermal_pkg.sv
// Types shared by the thermal monitor and analog mux controller
`default_nettype none
package thermal_pkg;
	typedef logic [5:0] thresh_vec_t;
	typedef logic [6:0] event_vec_t;
	typedef logic [4:0] mux_sel_t;
	typedef enum logic [1:0] {
		MON_OFF    = 2'b00,
		MON_ON     = 2'b01,
		MON_SAMPLE = 2'b10
	} monitor_mode_t;
endpackage
`default_nettype wire

// ### core/comparator_debounce.sv
// Synchroniser and bidirectional debounce filter for one comparator
`default_nettype none
`include "thermal_params.svh"
module comparator_debounce (
	input  wire logic i_mclk,      // System clock
	input  wire logic i_reset_n,   // Async reset, active low
	input  wire logic i_tick,      // 100 kHz enable pulse
	input  wire logic i_sample_en, // Comparator powered and valid
	input  wire logic i_cmp_raw,   // Raw comparator output
	output logic      o_level      // Debounced level
);
	localparam logic [3:0] DB_TICKS = 4'(`DEBOUNCE_TICKS);

	logic       sync_a;
	logic       sync_b;
	logic [3:0] cnt;

	// Two-stage synchroniser, first stage read only by the second
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= i_cmp_raw;
			sync_b <= sync_a;
		end
	end

	// Any return to the held level restarts the count, so a glitch
	// shorter than the debounce time never reaches the output
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt     <= 4'h0;
			o_level <= 1'b0;
		end else if (!i_sample_en || sync_b == o_level) begin
			cnt <= 4'h0;
		end else if (i_tick) begin
			if (cnt == DB_TICKS) begin
				o_level <= sync_b;
				cnt     <= 4'h0;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end

	property p_db_change;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(o_level != $past(o_level)) |->
			$past(i_tick) && $past(i_sample_en) &&
			$past(cnt) == DB_TICKS;
	endproperty
	a_db_change: assert property (p_db_change)
		else $error("debounced level changed without full count");
endmodule // comparator_debounce
`default_nettype wire

// ### core/thermal_monitor_analog_channel_mux_ctrl.sv
// Thermal monitor control, interrupts and analog mux over APB
//
// Contract
// - Six warning thresholds, each irq, sense, mask
// - Threshold crossing sets its interrupt bit
// - Sense releases only below hysteresis margin
// - Shutdown crossing holds off until cooled
// - Every comparator debounced both directions
// - Monitor enable cleared disables monitoring entirely
// - Run: always on, or 450us per 3ms
// - Standby: sampling only, needs monitor enable
// - Mux enable steals power-good pin
// - Select 0 high impedance, 7 die temperature
// - Mux enabled only in system On states
// - Logic and debounce timed by 100 kHz
// - Unmasked set interrupt bit drives pin low
`default_nettype none
`include "thermal_params.svh"
module thermal_monitor_analog_channel_mux_ctrl (
	input  wire logic                  i_mclk,          // 40 MHz clock
	input  wire logic                  i_reset_n,       // Async reset
	input  wire logic                  i_psel,          // APB select
	input  wire logic                  i_penable,       // APB enable
	input  wire logic                  i_pwrite,        // APB write
	input  wire logic [11:0]           i_paddr,         // APB address
	input  wire logic [31:0]           i_pwdata,        // APB wdata
	output logic      [31:0]           o_prdata,        // APB rdata
	output logic                       o_pready,        // APB ready
	output logic                       o_pslverr,       // APB error
	input  wire logic                  i_run_state,     // Run state
	input  wire logic                  i_standby_state, // Standby
	input  wire logic                  i_system_on,     // Any On state
	input  wire logic                  i_power_good,    // Normal pg level
	input  wire thermal_pkg::thresh_vec_t i_thresh_cmp, // Warn comps
	input  wire logic                  i_shutdown_cmp,  // Shutdown comp
	output logic                       o_monitor_power, // Sensor power
	output logic                       o_thermal_shutdown, // Shutdown
	output logic                       o_interrupt_out_n,  // IRQ pin
	output logic                       o_analog_mux_enable, // Mux on
	output logic                       o_die_temperature_channel, // Ch7
	output logic                       o_power_good_pin_out,  // Pin data
	output logic                       o_power_good_pin_oe_n  // Pin oe
);
	import thermal_pkg::*;

	localparam logic [8:0] LF_LAST   = 9'(`LF_DIV - 1);
	localparam logic [8:0] WIN_TICKS = 9'(`SAMPLE_WINDOW_TICKS);
	localparam logic [8:0] PER_LAST  = 9'(`SAMPLE_PERIOD_TICKS - 1);

	logic          lf_tick;
	logic [8:0]    lf_cnt;
	logic [8:0]    sample_cnt;
	monitor_mode_t mode;
	monitor_mode_t next_mode;
	logic          mon_enable;
	logic          mon_always_on;
	logic          mux_enable;
	mux_sel_t      mux_sel;
	event_vec_t    irq_mask;
	event_vec_t    irq_status;
	event_vec_t    level;
	event_vec_t    level_d;
	event_vec_t    evt;
	logic          wr_en;
	logic          mux_active;
	logic [31:0]   rd_value;
	logic          rd_hit;

	// Register decode, shared by the read path and the write strobes
	function automatic logic reg_is(input logic [11:0] a,
			input logic [11:0] off);
		reg_is = (a == off);
	endfunction

	// 100 kHz enable from the 40 MHz clock: all timers count this
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lf_cnt  <= 9'h000;
			lf_tick <= 1'b0;
		end else if (lf_cnt == LF_LAST) begin
			lf_cnt  <= 9'h000;
			lf_tick <= 1'b1;
		end else begin
			lf_cnt  <= lf_cnt + 9'h001;
			lf_tick <= 1'b0;
		end
	end

	// Debounced comparators: six warnings then shutdown in bit six
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_db
			comparator_debounce u_db (
				.i_mclk      (i_mclk),
				.i_reset_n   (i_reset_n),
				.i_tick      (lf_tick),
				.i_sample_en (o_monitor_power),
				.i_cmp_raw   ((gi == 6) ? i_shutdown_cmp
					: i_thresh_cmp[gi % 6]),
				.o_level     (level[gi])
			);
		end
	endgenerate

	// Rising debounced level is a crossing event; shutdown tracks the
	// debounced trip comparator, whose hysteresis lives in the analog
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			level_d            <= 7'h00;
			o_thermal_shutdown <= 1'b0;
		end else begin
			level_d            <= level;
			o_thermal_shutdown <= level[`EVT_SHUTDOWN];
		end
	end
	assign evt = level & ~level_d;

	// Power mode; standby never gets always-on, shutdown keeps sampling
	// so that cooling can be seen while the rails are down
	always_comb begin
		if (!mon_enable) begin
			next_mode = MON_OFF;
		end else if (i_run_state && mon_always_on) begin
			next_mode = MON_ON;
		end else if (i_run_state || i_standby_state ||
				o_thermal_shutdown) begin
			next_mode = MON_SAMPLE;
		end else begin
			next_mode = MON_OFF;
		end
	end
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mode <= MON_OFF;
		end else begin
			mode <= next_mode;
		end
	end

	// Sampling period counter, restarted whenever sampling stops
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sample_cnt <= 9'h000;
		end else if (mode != MON_SAMPLE) begin
			sample_cnt <= 9'h000;
		end else if (lf_tick) begin
			if (sample_cnt == PER_LAST) begin
				sample_cnt <= 9'h000;
			end else begin
				sample_cnt <= sample_cnt + 9'h001;
			end
		end
	end

	// Sensor power: on in always-on mode, window at start of period
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_monitor_power <= 1'b0;
		end else begin
			case (mode)
				MON_ON:     o_monitor_power <= 1'b1;
				MON_SAMPLE: o_monitor_power <= (sample_cnt < WIN_TICKS);
				MON_OFF:    o_monitor_power <= 1'b0;
				default:    o_monitor_power <= 1'b0;
			endcase
		end
	end

	// APB: no wait state, answer registered in the setup cycle
	assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
	always_comb begin
		rd_value = 32'h0000_0000;
		rd_hit   = 1'b1;
		if (reg_is(i_paddr, `REG_CTRL)) begin
			rd_value[`CTRL_MON_EN]  = mon_enable;
			rd_value[`CTRL_MON_AON] = mon_always_on;
			rd_value[`CTRL_MUX_EN]  = mux_enable;
			rd_value[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = mux_sel;
		end else if (reg_is(i_paddr, `REG_STATUS)) begin
			rd_value[6:0] = irq_status;
		end else if (reg_is(i_paddr, `REG_MASK)) begin
			rd_value[6:0] = irq_mask;
		end else if (reg_is(i_paddr, `REG_SENSE)) begin
			rd_value[6:0] = level;
			rd_value[`SENSE_POWERED] = o_monitor_power;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel && !i_penable;
			if (i_psel && !i_penable) begin
				o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_value;
				o_pslverr <= !rd_hit;
			end
		end
	end

	// Control register: steers monitor power and the pin mux
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mon_enable    <= `CTRL_MON_EN_RST;
			mon_always_on <= `CTRL_MON_AON_RST;
			mux_enable    <= `CTRL_MUX_EN_RST;
			mux_sel       <= `CTRL_SEL_RST;
		end else if (wr_en && reg_is(i_paddr, `REG_CTRL)) begin
			mon_enable    <= i_pwdata[`CTRL_MON_EN];
			mon_always_on <= i_pwdata[`CTRL_MON_AON];
			mux_enable    <= i_pwdata[`CTRL_MUX_EN];
			mux_sel       <= i_pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
		end
	end

	// Mask register, a one masks its event
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_mask <= `MASK_RST;
		end else if (wr_en && reg_is(i_paddr, `REG_MASK)) begin
			irq_mask <= i_pwdata[6:0];
		end
	end

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_status <= 7'h00;
		end else if (wr_en && reg_is(i_paddr, `REG_STATUS)) begin
			irq_status <= (irq_status & ~i_pwdata[6:0]) | evt;
		end else begin
			irq_status <= irq_status | evt;
		end
	end

	// Interrupt pin low while any unmasked bit is set
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_interrupt_out_n <= 1'b1;
		end else begin
			o_interrupt_out_n <= ~|(irq_status & ~irq_mask);
		end
	end

	// Pin mux: reserved codes, like the Hi-Z code, leave the mux enabled with no channel output
	assign mux_active = mux_enable && i_system_on;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_analog_mux_enable       <= 1'b0;
			o_die_temperature_channel <= 1'b0;
			o_power_good_pin_out      <= 1'b0;
			o_power_good_pin_oe_n     <= 1'b0;
		end else begin
			o_analog_mux_enable   <= mux_active;
			o_die_temperature_channel <= mux_active &&
				(mux_sel == `MUX_SEL_DIE_TEMP);
			o_power_good_pin_out  <= i_power_good;
			o_power_good_pin_oe_n <= mux_active;
		end
	end

	property p_irq_set;
		@(posedge i_mclk) disable iff (!i_reset_n)
		|evt |=> ((irq_status & $past(evt)) == $past(evt));
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("crossing event did not set interrupt bit");
	property p_irq_hold;
		@(posedge i_mclk) disable iff (!i_reset_n)
		!(wr_en && reg_is(i_paddr, `REG_STATUS)) |=>
			((irq_status & $past(irq_status)) == $past(irq_status));
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt bit lost without a clear");
	property p_int_pin;
		@(posedge i_mclk) disable iff (!i_reset_n)
		##1 (o_interrupt_out_n ==
			!(|($past(irq_status) & ~$past(irq_mask))));
	endproperty
	a_int_pin: assert property (p_int_pin)
		else $error("interrupt pin disagrees with unmasked status");
	property p_mon_off;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(!mon_enable && !o_thermal_shutdown) |-> ##2 !o_monitor_power;
	endproperty
	a_mon_off: assert property (p_mon_off)
		else $error("monitor powered while disabled");
	property p_aon;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(mon_enable && mon_always_on && i_run_state) |->
			##2 o_monitor_power;
	endproperty
	a_aon: assert property (p_aon)
		else $error("always-on run mode left monitor unpowered");
	property p_window;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(mode == MON_SAMPLE && sample_cnt >= WIN_TICKS) |=>
			!o_monitor_power;
	endproperty
	a_window: assert property (p_window)
		else $error("monitor powered outside sampling window");
	property p_standby;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(mode == MON_ON) |-> $past(i_run_state) && $past(mon_enable);
	endproperty
	a_standby: assert property (p_standby)
		else $error("always-on mode outside run state");
	property p_mux_off;
		@(posedge i_mclk) disable iff (!i_reset_n)
		!(mux_enable && i_system_on) |=>
			!o_power_good_pin_oe_n && !o_analog_mux_enable;
	endproperty
	a_mux_off: assert property (p_mux_off)
		else $error("pin not returned to power-good function");
	property p_temp_sel;
		@(posedge i_mclk) disable iff (!i_reset_n)
		o_die_temperature_channel |-> o_analog_mux_enable &&
			$past(mux_sel) == `MUX_SEL_DIE_TEMP && $past(i_system_on);
	endproperty
	a_temp_sel: assert property (p_temp_sel)
		else $error("temperature channel without its select code");
	property p_shutdown;
		@(posedge i_mclk) disable iff (!i_reset_n)
		$rose(level[`EVT_SHUTDOWN]) |=>
			o_thermal_shutdown && irq_status[`EVT_SHUTDOWN];
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("shutdown crossing not acted on");
endmodule // thermal_monitor_analog_channel_mux_ctrl
`default_nettype wire

// ### tb/thermal_sensor_model.sv
// Behavioural model of the die temperature threshold comparators
`default_nettype none
module thermal_sensor_model (
	input  wire logic       i_mclk,    // System clock
	input  wire logic       i_powered, // Sensor powered
	input  wire logic [7:0] i_temp_c,  // Die temperature in degrees
	output logic      [5:0] o_warn,    // Warning comparators
	output logic            o_trip     // Shutdown comparator
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] held  = 7'h00;
	logic [6:0] shown = 7'h00;
	// Analog hysteresis: a level is kept until the die cools past the margin
	always @(posedge i_mclk) begin
		for (int k = 0; k < 6; k++) begin
			if (i_temp_c >= 8'(80 + 15 * k))
				held[k] <= 1'b1;
			else if (i_temp_c < 8'(75 + 15 * k))
				held[k] <= 1'b0;
		end
		if (i_temp_c >= 8'hA5)
			held[6] <= 1'b1;
		else if (i_temp_c < 8'h96)
			held[6] <= 1'b0;
	end
	// Unpowered comparators are not valid, so they chatter every cycle
	always @(posedge i_mclk) begin
		if (i_powered)
			shown <= held;
		else
			shown <= ~shown;
	end
	assign o_warn = shown[5:0];
	assign o_trip = shown[6];
endmodule // thermal_sensor_model
`default_nettype wire

// ### tb/thermal_monitor_analog_channel_mux_ctrl_tb.sv
// Register-level testbench for the thermal monitor and analog mux
`default_nettype none
`include "thermal_params.svh"
module thermal_monitor_analog_channel_mux_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_mclk, i_reset_n, i_psel, i_penable, i_pwrite;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, q;
	logic        o_pready, o_pslverr, err;
	logic        i_run_state, i_standby_state, i_system_on, i_power_good;
	logic [5:0]  i_thresh_cmp;
	logic        i_shutdown_cmp, o_monitor_power, o_thermal_shutdown;
	logic        o_interrupt_out_n, o_analog_mux_enable;
	logic        o_die_temperature_channel, o_power_good_pin_out;
	logic        o_power_good_pin_oe_n;
	logic [7:0]  temp_c;
	int          fail_count = 0;
	int          tests_run  = 0;
	int          cycles     = 0;

	thermal_monitor_analog_channel_mux_ctrl dut_u (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_run_state(i_run_state),
		.i_standby_state(i_standby_state), .i_system_on(i_system_on),
		.i_power_good(i_power_good), .i_thresh_cmp(i_thresh_cmp),
		.i_shutdown_cmp(i_shutdown_cmp),
		.o_monitor_power(o_monitor_power),
		.o_thermal_shutdown(o_thermal_shutdown),
		.o_interrupt_out_n(o_interrupt_out_n),
		.o_analog_mux_enable(o_analog_mux_enable),
		.o_die_temperature_channel(o_die_temperature_channel),
		.o_power_good_pin_out(o_power_good_pin_out),
		.o_power_good_pin_oe_n(o_power_good_pin_oe_n));
	thermal_sensor_model sensor_u (.i_mclk(i_mclk),
		.i_powered(o_monitor_power), .i_temp_c(temp_c),
		.o_warn(i_thresh_cmp), .o_trip(i_shutdown_cmp));

	// Clock: 25 ns period
	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// A hung handshake is caught here rather than waiting forever
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 80000) begin
			fail_count++;
			tally_and_finish;
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge i_mclk);
		i_psel    <= 1'b1;
		i_pwrite  <= w;
		i_paddr   <= a;
		i_pwdata  <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		do @(posedge i_mclk); while (o_pready !== 1'b1);
		q = o_prdata;
		err = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, {24'h00_0000, e});
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	initial begin
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
		{i_run_state, i_standby_state, i_system_on, i_power_good} = '0;
		temp_c = 8'h19;
		i_reset_n = 1'b0;
		wt(4);
		i_reset_n <= 1'b1;
		rdc(`REG_CTRL, 8'h01);
		rdc(`REG_STATUS, 8'h00);
		rdc(`REG_MASK, 8'h7F);
		rdc(`REG_SENSE, 8'h00);
		rdc(12'h010, 8'h00);
		chk({31'h0, err}, 32'h0000_0001);
		// Run state, always on, threshold 0 unmasked
		i_run_state <= 1'b1;
		apb(1'b1, `REG_CTRL, 32'h0000_0003);
		apb(1'b1, `REG_MASK, 32'h0000_007E);
		wt(4);
		chk({31'h0, o_monitor_power}, 32'h0000_0001);
		// A spike shorter than the debounce time must not register
		temp_c <= 8'h5F;
		wt(100);
		temp_c <= 8'h19;
		wt(1200);
		rdc(`REG_SENSE, 8'h80);
		rdc(`REG_STATUS, 8'h00);
		temp_c <= 8'h55;
		wt(1200);
		rdc(`REG_SENSE, 8'h81);
		rdc(`REG_STATUS, 8'h01);
		chk({31'h0, o_interrupt_out_n}, 32'h0000_0000);
		temp_c <= 8'h4E;
		wt(1200);
		rdc(`REG_SENSE, 8'h81);
		temp_c <= 8'h46;
		wt(1200);
		rdc(`REG_SENSE, 8'h80);
		rdc(`REG_STATUS, 8'h01);
		apb(1'b1, `REG_STATUS, 32'h0000_0001);
		rdc(`REG_STATUS, 8'h00);
		chk({31'h0, o_interrupt_out_n}, 32'h0000_0001);
		// Every threshold and shutdown at once
		temp_c <= 8'hAA;
		wt(1200);
		rdc(`REG_SENSE, 8'hFF);
		rdc(`REG_STATUS, 8'h7F);
		chk({31'h0, o_thermal_shutdown}, 32'h0000_0001);
		apb(1'b1, `REG_MASK, 32'h0000_007F);
		wt(3);
		chk({31'h0, o_interrupt_out_n}, 32'h0000_0001);
		temp_c <= 8'h9B;
		wt(1200);
		chk({31'h0, o_thermal_shutdown}, 32'h0000_0001);
		temp_c <= 8'h95;
		wt(1200);
		chk({31'h0, o_thermal_shutdown}, 32'h0000_0000);
		rdc(`REG_SENSE, 8'h9F);
		// Disabled monitor: unpowered, levels frozen despite cooling
		temp_c <= 8'h19;
		apb(1'b1, `REG_CTRL, 32'h0000_0000);
		wt(4);
		chk({31'h0, o_monitor_power}, 32'h0000_0000);
		wt(1200);
		rdc(`REG_SENSE, 8'h1F);
		apb(1'b1, `REG_CTRL, 32'h0000_0001);
		wt(4);
		chk({31'h0, o_monitor_power}, 32'h0000_0001);
		// Standby samples even with always-on set; window ends in 45 ticks
		i_run_state     <= 1'b0;
		i_standby_state <= 1'b1;
		apb(1'b1, `REG_CTRL, 32'h0000_0003);
		wt(19000);
		chk({31'h0, o_monitor_power}, 32'h0000_0000);
		// Analog mux channel codes
		i_system_on <= 1'b1;
		apb(1'b1, `REG_CTRL, 32'h0000_0074);
		wt(3);
		chk({29'h0, o_analog_mux_enable, o_die_temperature_channel,
			o_power_good_pin_oe_n}, 32'h0000_0007);
		apb(1'b1, `REG_CTRL, 32'h0000_0004);
		wt(3);
		chk({29'h0, o_analog_mux_enable, o_die_temperature_channel,
			o_power_good_pin_oe_n}, 32'h0000_0005);
		apb(1'b1, `REG_CTRL, 32'h0000_0034);
		wt(3);
		chk({30'h0, o_analog_mux_enable, o_die_temperature_channel},
			32'h0000_0002);
		i_system_on <= 1'b0;
		wt(3);
		chk({30'h0, o_analog_mux_enable, o_power_good_pin_oe_n},
			32'h0000_0000);
		i_system_on <= 1'b1;
		i_power_good <= 1'b1;
		apb(1'b1, `REG_CTRL, 32'h0000_0000);
		wt(3);
		chk({30'h0, o_power_good_pin_oe_n, o_power_good_pin_out},
			32'h0000_0001);
		tally_and_finish;
	end
endmodule // thermal_monitor_analog_channel_mux_ctrl_tb
`default_nettype wire
